// *** rtl/asb_chan_if.sv ***
`timescale 1ns/10ps
// Per-channel bus and format bundle between top and channel
interface asb_chan_if;
  logic wr_hold;
  logic rd_fifo;
  logic [7:0] wdata;
  logic [7:0] hold_q;
  logic [7:0] fifo_q;
  logic [2:0] fmt;
  logic even_odd;
  logic clr_ovr;
  logic rx_full;
  logic ovr;
  logic perr;
  logic ferr;
  logic tx_empty;
  modport top (output wr_hold, rd_fifo, wdata, fmt, even_odd, clr_ovr,
    input hold_q, fifo_q, rx_full, ovr, perr, ferr, tx_empty);
  modport chan (input wr_hold, rd_fifo, wdata, fmt, even_odd, clr_ovr,
    output hold_q, fifo_q, rx_full, ovr, perr, ferr, tx_empty);
endinterface

// *** rtl/asb_pkg.sv ***
// Summary of operation
// RULE1 - Transmit shift register sends its loaded byte serially on the output pin.
// RULE2 - After a frame, a waiting holding byte loads automatically and starts sending.
// RULE3 - With nothing to send, the output pin idles steadily high.
// RULE4 - Holding byte moves to shifter once empty; writes allowed while shifting.
// RULE5 - Holding register reads back its value; reading never disturbs transmission.
// RULE6 - Holding registers decode at I/O 06h for channel 0, 07h for channel 1.
// RULE7 - Receive shifter assembles a character, then moves it to FIFO if room.
// RULE8 - New character completing while shifter still holds one flags overrun.
// RULE9 - Each completed character enters a four-deep first-in first-out buffer.
// RULE10 - Reading the receive data register returns the oldest FIFO character.
// RULE11 - Receive data register is read-only, at I/O 08h and 09h.
// RULE12 - Receiver keeps shifting while FIFO is full, holding one extra character.
// RULE13 - Full flag sets when a character enters an empty FIFO, even if erroneous.
// RULE14 - Frame is start, 7 or 8 data, optional parity, one or two stops.
// RULE15 - Two channels, each with its own independent transmit and receive path.
// RULE16 - Overrun stays latched in a readable flag until software clears it.
package asb_pkg;
  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_TX_HOLD_CH0 = 8'h06;
  localparam logic [7:0] ADDR_TX_HOLD_CH1 = 8'h07;
  localparam logic [7:0] ADDR_RX_READ_CH0 = 8'h08;
  localparam logic [7:0] ADDR_RX_READ_CH1 = 8'h09;
  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_DEPTH_CNT = 3'h4;
  localparam logic [3:0] OVERSAMPLE = 4'hF;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} asb_state_e;
endpackage

// *** rtl/asb_rx.sv ***
`timescale 1ns/10ps
module asb_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic samp_tick,
  input wire logic rx_in,
  input wire logic rd_fifo,
  input wire logic clr_ovr,
  input wire logic [2:0] fmt,
  input wire logic even_odd,
  output logic [7:0] fifo_q,
  output logic rx_full,
  output logic ovr,
  output logic perr,
  output logic ferr
);
  // ****************************************************************
  // Receive shifter, one-deep hold, and FIFO
  // ****************************************************************
  logic [7:0] mem_ff [asb_pkg::FIFO_DEPTH];
  logic [7:0] nxt_mem [asb_pkg::FIFO_DEPTH];
  logic [1:0] rp_ff, nxt_rp, wp_ff, nxt_wp;
  logic [2:0] cnt_ff, nxt_cnt;
  asb_pkg::asb_state_e st_ff, nxt_st;
  logic [3:0] ph_ff, nxt_ph, nb_ff, nxt_nb;
  logic [8:0] sh_ff, nxt_sh;
  logic [7:0] held_ff, nxt_held;
  logic held_v_ff, nxt_held_v;
  logic stop2_ff, nxt_stop2;
  logic ovr_ff, nxt_ovr, perr_ff, nxt_perr, ferr_ff, nxt_ferr;

  function automatic logic [3:0] data_bits(input logic [2:0] f);
    data_bits = (f[2] ? asb_pkg::BITS_8 : asb_pkg::BITS_7) + {3'h0, f[1]};
  endfunction

  // Next state: sample frame, hand off to FIFO
  always_comb begin
    logic [7:0] ch;
    logic pbit, push, pop;
    ch = asb_pkg::DATA_RESET;
    pbit = 1'b0;
    push = 1'b0;
    pop = rd_fifo && (cnt_ff != 3'h0); // [RULE10]
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_nb = nb_ff;
    nxt_sh = sh_ff;
    nxt_held = held_ff;
    nxt_held_v = held_v_ff;
    nxt_stop2 = stop2_ff;
    nxt_ovr = clr_ovr ? 1'b0 : ovr_ff;
    // Clear first, so an error in the same cycle still sets
    nxt_perr = clr_ovr ? 1'b0 : perr_ff;
    nxt_ferr = clr_ovr ? 1'b0 : ferr_ff;
    nxt_mem = mem_ff;
    nxt_rp = rp_ff;
    nxt_wp = wp_ff;
    // Held character moves into FIFO when there is room [RULE7] [RULE9]
    if (held_v_ff && (cnt_ff != asb_pkg::FIFO_DEPTH_CNT || pop)) begin
      push = 1'b1;
      nxt_mem[wp_ff] = held_ff;
      nxt_wp = wp_ff + 2'h1;
      nxt_held_v = 1'b0;
    end
    if (pop) nxt_rp = rp_ff + 2'h1;
    if (samp_tick) begin
      nxt_ph = ph_ff + 4'h1;
      unique case (st_ff)
        asb_pkg::ST_IDLE: begin
          nxt_ph = 4'h0;
          if (!rx_in) nxt_st = asb_pkg::ST_START;
        end
        asb_pkg::ST_START: if (ph_ff == asb_pkg::HALF_BIT) begin
          nxt_ph = 4'h0;
          nxt_nb = 4'h0;
          nxt_st = rx_in ? asb_pkg::ST_IDLE : asb_pkg::ST_BITS;
        end
        asb_pkg::ST_BITS: if (ph_ff == asb_pkg::OVERSAMPLE) begin
          nxt_sh = {rx_in, sh_ff[8:1]}; // Keeps shifting even when FIFO full [RULE12]
          nxt_nb = nb_ff + 4'h1;
          if (nb_ff + 4'h1 == data_bits(fmt)) nxt_st = asb_pkg::ST_STOP; // [RULE14]
        end
        asb_pkg::ST_STOP: if (ph_ff == asb_pkg::OVERSAMPLE) begin
          if (fmt[0] && !stop2_ff && rx_in) begin
            nxt_stop2 = 1'b1;
          end else begin
            nxt_stop2 = 1'b0;
            nxt_st = asb_pkg::ST_IDLE;
            // Right-align the assembled bits
            ch = fmt[2] ? (fmt[1] ? sh_ff[7:0] : sh_ff[8:1]) :
              (fmt[1] ? {1'b0, sh_ff[8:2]} : {1'b0, sh_ff[8:2]});
            if (!fmt[2] && !fmt[1]) ch = {1'b0, sh_ff[8:2]};
            if (!fmt[2] && fmt[1]) ch = {1'b0, sh_ff[7:1]};
            pbit = sh_ff[8];
            if (!rx_in) nxt_ferr = 1'b1;
            if (fmt[1] && ((^ch) ^ pbit ^ even_odd)) nxt_perr = 1'b1;
            // Erroneous characters are still stored [RULE13]
            if (nxt_held_v) nxt_ovr = 1'b1; // Set beats clear [RULE8] [RULE16]
            else begin
              nxt_held = ch;
              nxt_held_v = 1'b1;
            end
          end
        end
      endcase
    end
    nxt_cnt = cnt_ff + {2'h0, push} - {2'h0, pop};
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < asb_pkg::FIFO_DEPTH; i++) mem_ff[i] <= asb_pkg::DATA_RESET;
      rp_ff <= 2'h0;
      wp_ff <= 2'h0;
      cnt_ff <= 3'h0;
      st_ff <= asb_pkg::ST_IDLE;
      ph_ff <= 4'h0;
      nb_ff <= 4'h0;
      sh_ff <= 9'h000;
      held_ff <= asb_pkg::DATA_RESET;
      held_v_ff <= 1'b0;
      stop2_ff <= 1'b0;
      ovr_ff <= 1'b0;
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      rp_ff <= nxt_rp;
      wp_ff <= nxt_wp;
      cnt_ff <= nxt_cnt;
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      nb_ff <= nxt_nb;
      sh_ff <= nxt_sh;
      held_ff <= nxt_held;
      held_v_ff <= nxt_held_v;
      stop2_ff <= nxt_stop2;
      ovr_ff <= nxt_ovr;
      perr_ff <= nxt_perr;
      ferr_ff <= nxt_ferr;
    end
  end

  assign fifo_q = mem_ff[rp_ff]; // Oldest character [RULE10]
  assign rx_full = cnt_ff != 3'h0; // [RULE13]
  assign ovr = ovr_ff;
  assign perr = perr_ff;
  assign ferr = ferr_ff;

  chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    cnt_ff <= asb_pkg::FIFO_DEPTH_CNT)
    else $error("fifo count over depth");
  chk_full_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    (cnt_ff == 3'h0 && held_v_ff) |=> rx_full)
    else $error("full flag not set on first entry");
  chk_ovr_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
    (ovr_ff && !clr_ovr) |=> ovr_ff)
    else $error("overrun flag dropped");
  chk_pop_order: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
    (rd_fifo && cnt_ff > 3'h1) |=> fifo_q == $past(mem_ff[rp_ff + 2'h1]))
    else $error("fifo order broken");
endmodule

// *** rtl/asb_top.sv ***
`timescale 1ns/10ps
module asb_top (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  input wire logic BIT_TICK,
  input wire logic SAMPLE_TICK,
  input wire logic [2:0] FMT_CH0,
  input wire logic [2:0] FMT_CH1,
  input wire logic PARITY_ODD_CH0,
  input wire logic PARITY_ODD_CH1,
  input wire logic [1:0] CLEAR_ERRORS,
  output logic [1:0] RX_FULL,
  output logic [1:0] OVERRUN,
  output logic [1:0] PARITY_ERR,
  output logic [1:0] FRAMING_ERR,
  output logic [1:0] TX_HOLD_EMPTY,
  input wire logic [1:0] SERIAL_IN_PIN,
  output logic [1:0] SERIAL_OUT_PIN
);
  // ****************************************************************
  // Input synchronisers and address decode
  // ****************************************************************
  logic [1:0] rx_meta_ff, rx_sync_ff;
  logic [7:0] rd_ff, nxt_rd;
  asb_chan_if ch [2] ();

  // Two-stage synchroniser for the serial pins
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rx_meta_ff <= 2'h3;
      rx_sync_ff <= 2'h3;
    end else begin
      rx_meta_ff <= SERIAL_IN_PIN;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // Read mux; receive registers ignore writes [RULE11]
  always_comb begin
    nxt_rd = rd_ff;
    if (IO_RD) begin
      unique case (IO_ADDR)
        asb_pkg::ADDR_TX_HOLD_CH0: nxt_rd = ch[0].hold_q; // [RULE5] [RULE6]
        asb_pkg::ADDR_TX_HOLD_CH1: nxt_rd = ch[1].hold_q;
        asb_pkg::ADDR_RX_READ_CH0: nxt_rd = ch[0].fifo_q; // [RULE11]
        asb_pkg::ADDR_RX_READ_CH1: nxt_rd = ch[1].fifo_q;
        default: nxt_rd = asb_pkg::DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) rd_ff <= asb_pkg::DATA_RESET;
    else rd_ff <= nxt_rd;
  end
  assign IO_RDATA = rd_ff;

  // ****************************************************************
  // Two independent channels
  // ****************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_ch // [RULE15]
    assign ch[g].wr_hold = IO_WR && (IO_ADDR == (g == 0 ? asb_pkg::ADDR_TX_HOLD_CH0 :
      asb_pkg::ADDR_TX_HOLD_CH1)); // [RULE6]
    assign ch[g].rd_fifo = IO_RD && (IO_ADDR == (g == 0 ? asb_pkg::ADDR_RX_READ_CH0 :
      asb_pkg::ADDR_RX_READ_CH1));
    assign ch[g].wdata = IO_WDATA;
    assign ch[g].fmt = g == 0 ? FMT_CH0 : FMT_CH1;
    assign ch[g].even_odd = g == 0 ? PARITY_ODD_CH0 : PARITY_ODD_CH1;
    assign ch[g].clr_ovr = CLEAR_ERRORS[g];
    asb_tx u_tx (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .bit_tick(BIT_TICK),
      .wr_hold(ch[g].wr_hold),
      .wdata(ch[g].wdata),
      .fmt(ch[g].fmt),
      .even_odd(ch[g].even_odd),
      .hold_q(ch[g].hold_q),
      .hold_empty(ch[g].tx_empty),
      .serial_out_pin(SERIAL_OUT_PIN[g])
    );
    asb_rx u_rx (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .samp_tick(SAMPLE_TICK),
      .rx_in(rx_sync_ff[g]),
      .rd_fifo(ch[g].rd_fifo),
      .clr_ovr(ch[g].clr_ovr),
      .fmt(ch[g].fmt),
      .even_odd(ch[g].even_odd),
      .fifo_q(ch[g].fifo_q),
      .rx_full(ch[g].rx_full),
      .ovr(ch[g].ovr),
      .perr(ch[g].perr),
      .ferr(ch[g].ferr)
    );
    assign RX_FULL[g] = ch[g].rx_full;
    assign OVERRUN[g] = ch[g].ovr; // [RULE16]
    assign PARITY_ERR[g] = ch[g].perr;
    assign FRAMING_ERR[g] = ch[g].ferr;
    assign TX_HOLD_EMPTY[g] = ch[g].tx_empty;
  end

  chk_rd_hold0: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE5]
    (IO_RD && IO_ADDR == asb_pkg::ADDR_TX_HOLD_CH0) |=> IO_RDATA == $past(ch[0].hold_q))
    else $error("holding readback wrong");
endmodule

// *** rtl/asb_tx.sv ***
`timescale 1ns/10ps
module asb_tx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_tick,
  input wire logic wr_hold,
  input wire logic [7:0] wdata,
  input wire logic [2:0] fmt,
  input wire logic even_odd,
  output logic [7:0] hold_q,
  output logic hold_empty,
  output logic serial_out_pin
);
  // ****************************************************************
  // Transmit holding and shift registers
  // ****************************************************************
  logic [7:0] hold_ff, nxt_hold;
  logic hold_full_ff, nxt_hold_full;
  logic [10:0] shift_ff, nxt_shift;
  logic [3:0] left_ff, nxt_left;
  logic line_ff, nxt_line;

  function automatic logic [3:0] frame_len(input logic [2:0] f);
    frame_len = 4'h2 + (f[2] ? asb_pkg::BITS_8 : asb_pkg::BITS_7)
      + {3'h0, f[1]} + {3'h0, f[0]};
  endfunction

  // Next state: load, shift, idle high
  always_comb begin
    logic [7:0] d;
    logic par;
    d = hold_ff;
    par = 1'b0;
    nxt_hold = hold_ff;
    nxt_hold_full = hold_full_ff;
    nxt_shift = shift_ff;
    nxt_left = left_ff;
    nxt_line = line_ff;
    if (bit_tick) begin
      if (left_ff != 4'h0) begin
        nxt_line = shift_ff[0]; // [RULE1]
        nxt_shift = {1'b1, shift_ff[10:1]};
        nxt_left = left_ff - 4'h1;
      end else if (hold_full_ff) begin
        // Load holding byte once the shifter drains [RULE2] [RULE4]
        if (!fmt[2]) d[7] = 1'b0;
        par = (^d) ^ even_odd;
        nxt_line = 1'b0;
        if (fmt[2]) nxt_shift = {2'h3, fmt[1] ? par : 1'b1, d}; // [RULE14]
        else nxt_shift = {3'h7, fmt[1] ? par : 1'b1, d[6:0]};
        nxt_left = frame_len(fmt) - 4'h1;
        nxt_hold_full = 1'b0;
      end else begin
        nxt_line = 1'b1; // [RULE3]
      end
    end
    // Write accepted even while shifting; set wins over load
    if (wr_hold) begin
      nxt_hold = wdata; // [RULE4]
      nxt_hold_full = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_ff <= asb_pkg::DATA_RESET;
      hold_full_ff <= 1'b0;
      shift_ff <= 11'h7FF;
      left_ff <= 4'h0;
      line_ff <= 1'b1;
    end else begin
      hold_ff <= nxt_hold;
      hold_full_ff <= nxt_hold_full;
      shift_ff <= nxt_shift;
      left_ff <= nxt_left;
      line_ff <= nxt_line;
    end
  end

  assign hold_q = hold_ff; // [RULE5]
  assign hold_empty = !hold_full_ff;
  assign serial_out_pin = line_ff;

  chk_idle_high: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
    (left_ff == 4'h0 && !hold_full_ff && bit_tick) |=> serial_out_pin)
    else $error("tx line not idle high");
  chk_load_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
    (left_ff == 4'h0 && hold_full_ff && bit_tick && !wr_hold) |=>
    (!serial_out_pin && !hold_full_ff && left_ff != 4'h0))
    else $error("tx load did not start frame");
  chk_write_kept: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    wr_hold |=> (hold_ff == $past(wdata) && hold_full_ff))
    else $error("tx write lost");
endmodule

// *** tb/asb_remote.sv ***
`timescale 1ns/10ps
// ****************************************************
// Far-end serial device, 16 clocks per bit
// ****************************************************
module asb_remote (
  input wire logic clk,
  input wire logic [2:0] fmt,
  input wire logic odd,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_q[$];
  logic [7:0] rd;
  initial line_out = 1'b1;
  // Start low, LSB first, parity, stops high; bad[0] flips parity, bad[1] drops stop
  task automatic send(input logic [7:0] d, input logic [1:0] bad);
    logic b[$];
    logic [7:0] m;
    m = fmt[2] ? 8'hFF : 8'h7F;
    b = {1'b0};
    for (int i = 0; i < (fmt[2] ? 8 : 7); i++) b.push_back(d[i]);
    if (fmt[1]) b.push_back(^(d & m) ^ odd ^ bad[0]);
    b.push_back(~bad[1]);
    if (fmt[0]) b.push_back(1'b1);
    @(negedge clk);
    foreach (b[i]) begin
      line_out = b[i];
      repeat (16) @(negedge clk);
    end
    line_out = 1'b1;
  endtask
  // Mid-bit sampling of frames coming from the device
  initial forever begin
    @(negedge line_in);
    repeat (8) @(posedge clk);
    rd = 8'h00;
    for (int i = 0; i < (fmt[2] ? 8 : 7); i++) begin
      repeat (16) @(posedge clk);
      rd[i] = line_in;
    end
    if (fmt[1]) begin
      repeat (16) @(posedge clk);
      if (line_in !== (^rd ^ odd)) rd = ~rd; // Spoil the byte on bad parity
    end
    repeat (16) @(posedge clk);
    if (line_in !== 1'b1) rd = ~rd; // Spoil the byte on a low stop bit
    got_q.push_back(rd);
  end
endmodule

// *** tb/async_serial_tx_rx_buffering_test.sv ***
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checked++; got_v = 8'(got); if (got_v !== 8'(exp)) begin \
  bad_count++; $display("mismatch %s expected %h seen %h", nm, 8'(exp), got_v); end end
module async_serial_tx_rx_buffering_test;
  typedef struct {logic ch; logic [2:0] fmt; logic odd; logic [7:0] d; logic [7:0] exp;} asb_row_s;
  logic clock = 1'b0, reset_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, bit_tick = 1'b0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, q;
  logic [1:0][2:0] fmt = '{3'h4, 3'h4};
  logic [1:0] odd = 2'b00, clr = 2'b00, sin, sout, rx_full, ovr, perr, ferr, hold_empty;
  logic [3:0] tick_cnt = 4'h0;
  int bad_count = 0, checked = 0;
  // Value under test is taken once, so a popping call runs only once
  logic [7:0] got_v;
  // One row per format, both channels in turn
  asb_row_s rows[8] = '{'{0, 3'h0, 0, 8'hA5, 8'h25}, '{1, 3'h1, 1, 8'h3C, 8'h3C},
    '{0, 3'h2, 0, 8'hFF, 8'h7F}, '{1, 3'h3, 1, 8'h81, 8'h01}, '{0, 3'h4, 0, 8'h00, 8'h00},
    '{1, 3'h5, 0, 8'hC3, 8'hC3}, '{0, 3'h6, 1, 8'h5A, 8'h5A}, '{1, 3'h7, 0, 8'h96, 8'h96}};
  // ****************************************************
  // Clock, baud tick, design and far ends
  // ****************************************************
  initial forever #4 clock = ~clock;
  // Sample tick tied high, so a bit lasts 16 clocks on both sides
  always @(negedge clock) begin
    tick_cnt <= tick_cnt + 4'h1;
    bit_tick <= (tick_cnt == 4'hF);
  end
  asb_top uut (.CLOCK(clock), .RESET_N(reset_n), .IO_ADDR(io_addr), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .BIT_TICK(bit_tick),
    .SAMPLE_TICK(1'b1), .FMT_CH0(fmt[0]), .FMT_CH1(fmt[1]), .PARITY_ODD_CH0(odd[0]),
    .PARITY_ODD_CH1(odd[1]), .CLEAR_ERRORS(clr), .RX_FULL(rx_full), .OVERRUN(ovr),
    .PARITY_ERR(perr), .FRAMING_ERR(ferr), .TX_HOLD_EMPTY(hold_empty),
    .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout));
  asb_remote r0 (.clk(clock), .fmt(fmt[0]), .odd(odd[0]), .line_in(sout[0]), .line_out(sin[0]));
  asb_remote r1 (.clk(clock), .fmt(fmt[1]), .odd(odd[1]), .line_in(sout[1]), .line_out(sin[1]));
  // ****************************************************
  // Bus cycles and waits
  // ****************************************************
  task automatic give_verdict;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    q = io_rdata;
  endtask
  function automatic logic cond(input int sel, input int ch);
    if (sel == 0) return rx_full[ch];
    if (sel == 1) return hold_empty[ch];
    return (ch ? r1.got_q.size() : r0.got_q.size()) > 0;
  endfunction
  // Bounded wait; running out ends the run as a failure
  task automatic wait_hi(input int sel, input int ch);
    for (int i = 0; i < 600 && cond(sel, ch) !== 1'b1; i++) @(negedge clock);
    if (cond(sel, ch) !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
  endtask
  function automatic logic [7:0] pop(input logic ch);
    return ch ? r1.got_q.pop_front() : r0.got_q.pop_front();
  endfunction
  task automatic send_on(input logic ch, input logic [7:0] d, input logic [1:0] bad);
    if (ch) r1.send(d, bad);
    else r0.send(d, bad);
  endtask
  function automatic logic [7:0] ta(input logic ch);
    return ch ? asb_pkg::ADDR_TX_HOLD_CH1 : asb_pkg::ADDR_TX_HOLD_CH0;
  endfunction
  function automatic logic [7:0] ra(input logic ch);
    return ch ? asb_pkg::ADDR_RX_READ_CH1 : asb_pkg::ADDR_RX_READ_CH0;
  endfunction
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    repeat (5) @(negedge clock);
    `CHK("idle lines", 2'b11, sout)
    `CHK("reset full", 2'b00, rx_full)
    reset_n = 1'b1;
    foreach (rows[i]) begin
      fmt[rows[i].ch] = rows[i].fmt;
      odd[rows[i].ch] = rows[i].odd;
      wr(ta(rows[i].ch), rows[i].d);
      wait_hi(2, rows[i].ch);
      `CHK("line byte", rows[i].exp, pop(rows[i].ch))
      send_on(rows[i].ch, rows[i].d, 1'b0);
      wait_hi(0, rows[i].ch);
      rd(ra(rows[i].ch));
      `CHK("rx byte", rows[i].exp, q)
    end
    // Second byte written while the first is still shifting
    fmt = '{3'h4, 3'h4};
    wr(ta(0), 8'h11);
    wait_hi(1, 0);
    wr(ta(0), 8'h22);
    rd(ta(0));
    `CHK("hold readback", 8'h22, q)
    wait_hi(2, 0);
    `CHK("first byte", 8'h11, pop(0))
    wait_hi(2, 0);
    `CHK("chained byte", 8'h22, pop(0))
    `CHK("idle after", 1'b1, sout[0])
    // Six frames unread: four queued, one held, last lost
    for (int k = 0; k < 6; k++) send_on(1, 8'h40 + 8'(k), 1'b0);
    repeat (8) @(negedge clock);
    `CHK("overrun", 1'b1, ovr[1])
    for (int k = 0; k < 5; k++) begin
      rd(ra(1));
      `CHK("fifo order", 8'h40 + 8'(k), q)
    end
    wr(ra(1), 8'hEE);
    repeat (4) @(negedge clock);
    `CHK("ro fifo", 1'b0, rx_full[1])
    `CHK("overrun held", 1'b1, ovr[1])
    clr = 2'b10;
    @(negedge clock);
    clr = 2'b00;
    @(negedge clock);
    `CHK("overrun cleared", 1'b0, ovr[1])
    rd(8'h00);
    `CHK("unmapped", 8'h00, q)
    // A character with bad parity still fills the empty queue
    fmt[0] = 3'h2;
    send_on(0, 8'h15, 1'b1);
    wait_hi(0, 0);
    `CHK("parity flag", 1'b1, perr[0])
    rd(ra(0));
    `CHK("bad char kept", 8'h15, q)
    // Both channels receive at once; channel 1 also transmits
    fmt = '{3'h4, 3'h4};
    fork
      send_on(0, 8'hAB, 1'b0);
      send_on(1, 8'hCD, 1'b0);
      wr(ta(1), 8'h6E);
    join
    wait_hi(0, 0);
    wait_hi(0, 1);
    wait_hi(2, 1);
    `CHK("ch1 line", 8'h6E, pop(1))
    rd(ra(0));
    `CHK("ch0 rx", 8'hAB, q)
    rd(ra(1));
    `CHK("ch1 rx", 8'hCD, q)
    // Low stop bit: the character still lands, with the framing flag
    `CHK("no framing yet", 1'b0, ferr[0])
    send_on(0, 8'h3A, 2'b10);
    wait_hi(0, 0);
    rd(ra(0));
    `CHK("framed char kept", 8'h3A, q)
    `CHK("framing flag", 1'b1, ferr[0])
    // Reset in mid-frame: lines idle, flags and holding register cleared
    wr(ta(1), 8'h77);
    wait_hi(1, 1);
    repeat (20) @(negedge clock);
    reset_n = 1'b0;
    @(negedge clock);
    `CHK("mid reset lines", 2'b11, sout)
    `CHK("mid reset full", 2'b00, rx_full)
    `CHK("mid reset hold", 2'b11, hold_empty)
    `CHK("mid reset flags", 6'h00, {ovr, perr, ferr})
    `CHK("mid reset rdata", 8'h00, io_rdata)
    @(negedge clock);
    reset_n = 1'b1;
    repeat (2) @(negedge clock);
    `CHK("idle after reset", 2'b11, sout)
    rd(ta(1));
    `CHK("hold after reset", 8'h00, q)
    wr(ta(0), 8'hC4);
    wait_hi(2, 0);
    `CHK("send after reset", 8'hC4, pop(0))
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
endmodule
